// ==== hdl/cid_defines.svh ====
// Opcode, cycle and address constants for the instruction decoder
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH
`define CID_OP_RJ_ALWAYS   8'h20
`define CID_OP_RJ_NEVER    8'h21
`define CID_OP_RJ_HIGHER   8'h22
`define CID_OP_RJ_LOWSAME  8'h23
`define CID_OP_RJ_CCLR     8'h24
`define CID_OP_RJ_CSET     8'h25
`define CID_OP_RJ_NONZERO  8'h26
`define CID_OP_RJ_ZERO     8'h27
`define CID_OP_RJ_HCLR     8'h28
`define CID_OP_RJ_HSET     8'h29
`define CID_OP_RJ_PLUS     8'h2A
`define CID_OP_RJ_MINUS    8'h2B
`define CID_OP_RJ_MCLR     8'h2C
`define CID_OP_RJ_MSET     8'h2D
`define CID_OP_RJ_ILOW     8'h2E
`define CID_OP_RJ_IHIGH    8'h2F
`define CID_OP_REL_CALL    8'hAD
`define CID_OP_PRODUCT     8'h42
`define CID_OP_CARRY_HIGH  8'h99
`define CID_OP_CARRY_LOW   8'h98
`define CID_OP_MASK_HIGH   8'h9B
`define CID_OP_MASK_LOW    8'h9A
`define CID_OP_ACC_TO_IDX  8'h97
`define CID_OP_IDX_TO_ACC  8'h9F
`define CID_OP_SP_INIT     8'h9C
`define CID_OP_IDLE        8'h9D
`define CID_OP_SOFT_TRAP   8'h83
`define CID_OP_CALL_RET    8'h81
`define CID_OP_TRAP_RET    8'h80
`define CID_OP_STOP        8'h8E
`define CID_OP_WAIT        8'h8F
`define CID_HI_BIT_JUMP    4'h0
`define CID_HI_BIT_FORCE   4'h1
`define CID_HI_RELATIVE    4'h2
`define CID_HI_RMW_DIR     4'h3
`define CID_HI_RMW_ACC     4'h4
`define CID_HI_RMW_IDX     4'h5
`define CID_HI_RMW_OFF8    4'h6
`define CID_HI_RMW_NOOFF   4'h7
`define CID_CYC_RMW_REG    4'd3
`define CID_CYC_RMW_DIR    4'd5
`define CID_CYC_RMW_NOOFF  4'd5
`define CID_CYC_RMW_OFF8   4'd6
`define CID_CYC_PRODUCT    4'd11
`define CID_CYC_REL        4'd3
`define CID_CYC_REL_CALL   4'd6
`define CID_CYC_BIT        4'd5
`define CID_CYC_CTRL       4'd2
`define CID_CYC_SOFT_TRAP  4'd10
`define CID_CYC_CALL_RET   4'd6
`define CID_CYC_TRAP_RET   4'd9
`define CID_LEN_ONE        2'd1
`define CID_LEN_TWO        2'd2
`define CID_LEN_THREE      2'd3
`define CID_ADDR_PORTD     8'h03
`define CID_ADDR_SPI_STAT  8'h0B
`define CID_ADDR_SCI_STAT  8'h10
`define CID_ADDR_TMR_STAT  8'h13
`define CID_ADDR_CAP_HI    8'h14
`define CID_ADDR_CAP_LO    8'h15
`define CID_ROM_PAGE_BASE  8'hD0
`endif

// ==== hdl/cid_pkg.sv ====
// Types shared by the instruction decoder files
package cid_pkg;
  typedef enum logic [3:0] {
    cid_mode_inherent, cid_mode_immediate, cid_mode_direct, cid_mode_extended,
    cid_mode_relative, cid_mode_idx_nooff, cid_mode_idx_off8, cid_mode_idx_off16,
    cid_mode_bit_setclr, cid_mode_bit_test, cid_mode_illegal
  } cid_mode_type;
  typedef enum logic [3:0] {
    cid_fn_sign_flip_op, cid_fn_invert_op, cid_fn_shift_right_logical,
    cid_fn_rotate_right_carry, cid_fn_shift_right_signed, cid_fn_shift_left_logical,
    cid_fn_rotate_left_carry, cid_fn_subtract_one_op, cid_fn_add_one_op,
    cid_fn_test_op, cid_fn_zero_op, cid_fn_none
  } cid_func_type;
  typedef enum logic [4:0] {
    cid_cls_none, cid_cls_rmw, cid_cls_product, cid_cls_rel_jump, cid_cls_rel_call,
    cid_cls_test_jump_bit_high, cid_cls_test_jump_bit_low, cid_cls_bit_force_high,
    cid_cls_bit_force_low, cid_cls_carry_force_high, cid_cls_carry_force_low,
    cid_cls_mask_force_high, cid_cls_mask_force_low, cid_cls_acc_to_index,
    cid_cls_index_to_acc, cid_cls_stack_ptr_init, cid_cls_idle_op, cid_cls_soft_trap,
    cid_cls_call_return, cid_cls_trap_return, cid_cls_stop, cid_cls_wait
  } cid_class_type;
endpackage : cid_pkg

// ==== hdl/cid_cond_eval.sv ====
// Branch condition test for relative jumps
`timescale 1ns/1ps
`include "cid_defines.svh"
module cid_cond_eval
  import cid_pkg::*;
(
  input  wire logic [3:0] cond_sel,
  input  wire logic       flag_carry,
  input  wire logic       flag_zero,
  input  wire logic       flag_half,
  input  wire logic       flag_neg,
  input  wire logic       flag_mask,
  input  wire logic       irq_line,
  output logic            taken
);
  always_comb
  begin
    unique case (cond_sel[3:1])
      3'h0: taken = 1'b1;
      3'h1: taken = ~(flag_carry | flag_zero);
      3'h2: taken = ~flag_carry;
      3'h3: taken = ~flag_zero;
      3'h4: taken = ~flag_half;
      3'h5: taken = ~flag_neg;
      3'h6: taken = ~flag_mask;
      3'h7: taken = ~irq_line;
    endcase
    // Odd codes invert the even test
    if (cond_sel[0])
    begin
      taken = ~taken;
    end
  end
endmodule : cid_cond_eval

// ==== hdl/cid_decode.sv ====
// Instruction decoder with cycle sequencing and operand location
`timescale 1ns/1ps
`include "cid_defines.svh"
module cid_decode
  import cid_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              op_valid,
  input  wire logic [7:0]        opcode,
  input  wire logic [7:0]        operand1,
  input  wire logic [7:0]        operand2,
  input  wire logic [7:0]        index_reg,
  input  wire logic [ADDR_W-1:0] pc,
  input  wire logic [7:0]        mem_byte,
  input  wire logic              flag_carry,
  input  wire logic              flag_zero,
  input  wire logic              flag_half,
  input  wire logic              flag_neg,
  input  wire logic              flag_mask,
  input  wire logic              irq_line,
  output logic                   busy,
  output logic                   done,
  output logic                   illegal,
  output logic [3:0]             cycles,
  output logic [1:0]             length,
  output cid_mode_type           mode,
  output cid_class_type          op_class,
  output cid_func_type           func,
  output logic [2:0]             bit_num,
  output logic [ADDR_W-1:0]      operand_location,
  output logic [ADDR_W-1:0]      next_pc,
  output logic                   jump_taken,
  output logic                   carry_load,
  output logic                   carry_value,
  output logic                   bit_refused
);
  logic [3:0]        hi;
  logic [3:0]        lo;
  logic [3:0]        next_cycles;
  logic [1:0]        next_length;
  cid_mode_type      next_mode;
  cid_class_type     next_class;
  cid_func_type      next_func;
  logic              cond_taken;
  logic              bit_val;
  logic [ADDR_W-1:0] next_loc;
  logic [ADDR_W-1:0] seq_pc;
  logic [ADDR_W-1:0] rel_target;
  logic              protected_loc;
  logic [3:0]        remain;
  logic              start;

  assign hi    = opcode[7:4];
  assign lo    = opcode[3:0];
  assign start = op_valid & ~busy;

  cid_cond_eval u_cond (
    .cond_sel   (lo),
    .flag_carry (flag_carry),
    .flag_zero  (flag_zero),
    .flag_half  (flag_half),
    .flag_neg   (flag_neg),
    .flag_mask  (flag_mask),
    .irq_line   (irq_line),
    .taken      (cond_taken)
  );

  // Class, mode, length and cycle count
  always_comb
  begin
    next_class  = cid_cls_none;
    next_mode   = cid_mode_illegal;
    next_func   = cid_fn_none;
    next_length = `CID_LEN_ONE;
    next_cycles = `CID_CYC_CTRL;
    if (opcode == `CID_OP_PRODUCT)
    begin
      next_class  = cid_cls_product;
      next_mode   = cid_mode_inherent;
      next_cycles = `CID_CYC_PRODUCT;
    end
    else if (hi >= `CID_HI_RMW_DIR && hi <= `CID_HI_RMW_NOOFF)
    begin
      unique case (lo)
        4'h0: next_func = cid_fn_sign_flip_op;
        4'h3: next_func = cid_fn_invert_op;
        4'h4: next_func = cid_fn_shift_right_logical;
        4'h6: next_func = cid_fn_rotate_right_carry;
        4'h7: next_func = cid_fn_shift_right_signed;
        4'h8: next_func = cid_fn_shift_left_logical;
        4'h9: next_func = cid_fn_rotate_left_carry;
        4'hA: next_func = cid_fn_subtract_one_op;
        4'hC: next_func = cid_fn_add_one_op;
        4'hD: next_func = cid_fn_test_op;
        4'hF: next_func = cid_fn_zero_op;
        default: next_func = cid_fn_none;
      endcase
      if (next_func != cid_fn_none)
      begin
        next_class = cid_cls_rmw;
        unique case (hi)
          `CID_HI_RMW_ACC, `CID_HI_RMW_IDX:
          begin
            next_mode   = cid_mode_inherent;
            next_cycles = `CID_CYC_RMW_REG;
          end
          `CID_HI_RMW_DIR:
          begin
            next_mode   = cid_mode_direct;
            next_length = `CID_LEN_TWO;
            next_cycles = `CID_CYC_RMW_DIR;
          end
          `CID_HI_RMW_NOOFF:
          begin
            next_mode   = cid_mode_idx_nooff;
            next_cycles = `CID_CYC_RMW_NOOFF;
          end
          default:
          begin
            next_mode   = cid_mode_idx_off8;
            next_length = `CID_LEN_TWO;
            next_cycles = `CID_CYC_RMW_OFF8;
          end
        endcase
        // Test only reads, so memory forms skip the write cycle
        if (next_func == cid_fn_test_op && next_mode != cid_mode_inherent)
          next_cycles = next_cycles - 4'd1;
      end
    end
    else if (hi == `CID_HI_RELATIVE || opcode == `CID_OP_REL_CALL)
    begin
      next_class  = (hi == `CID_HI_RELATIVE) ? cid_cls_rel_jump : cid_cls_rel_call;
      next_mode   = cid_mode_relative;
      next_length = `CID_LEN_TWO;
      next_cycles = (hi == `CID_HI_RELATIVE) ? `CID_CYC_REL : `CID_CYC_REL_CALL;
    end
    else if (hi == `CID_HI_BIT_JUMP)
    begin
      next_class  = lo[0] ? cid_cls_test_jump_bit_low : cid_cls_test_jump_bit_high;
      next_mode   = cid_mode_bit_test;
      next_length = `CID_LEN_THREE;
      next_cycles = `CID_CYC_BIT;
    end
    else if (hi == `CID_HI_BIT_FORCE)
    begin
      next_class  = lo[0] ? cid_cls_bit_force_low : cid_cls_bit_force_high;
      next_mode   = cid_mode_bit_setclr;
      next_length = `CID_LEN_TWO;
      next_cycles = `CID_CYC_BIT;
    end
    else
    begin
      next_mode = cid_mode_inherent;
      unique case (opcode)
        `CID_OP_CARRY_HIGH: next_class = cid_cls_carry_force_high;
        `CID_OP_CARRY_LOW:  next_class = cid_cls_carry_force_low;
        `CID_OP_MASK_HIGH:  next_class = cid_cls_mask_force_high;
        `CID_OP_MASK_LOW:   next_class = cid_cls_mask_force_low;
        `CID_OP_ACC_TO_IDX: next_class = cid_cls_acc_to_index;
        `CID_OP_IDX_TO_ACC: next_class = cid_cls_index_to_acc;
        `CID_OP_SP_INIT:    next_class = cid_cls_stack_ptr_init;
        `CID_OP_IDLE:       next_class = cid_cls_idle_op;
        `CID_OP_STOP:       next_class = cid_cls_stop;
        `CID_OP_WAIT:       next_class = cid_cls_wait;
        `CID_OP_SOFT_TRAP:
        begin
          next_class  = cid_cls_soft_trap;
          next_cycles = `CID_CYC_SOFT_TRAP;
        end
        `CID_OP_CALL_RET:
        begin
          next_class  = cid_cls_call_return;
          next_cycles = `CID_CYC_CALL_RET;
        end
        `CID_OP_TRAP_RET:
        begin
          next_class  = cid_cls_trap_return;
          next_cycles = `CID_CYC_TRAP_RET;
        end
        default: next_mode = cid_mode_illegal;
      endcase
    end
  end

  // Operand location; bit forms stay in page zero
  always_comb
  begin
    unique case (next_mode)
      cid_mode_direct, cid_mode_bit_setclr, cid_mode_bit_test:
        next_loc = {{(ADDR_W-8){1'b0}}, operand1};
      cid_mode_extended: next_loc = ADDR_W'({operand1, operand2});
      cid_mode_idx_nooff: next_loc = {{(ADDR_W-8){1'b0}}, index_reg};
      cid_mode_idx_off8: next_loc = ADDR_W'({8'h00, operand1} + {8'h00, index_reg});
      cid_mode_idx_off16: next_loc = ADDR_W'({operand1, operand2} + {8'h00, index_reg});
      cid_mode_immediate: next_loc = ADDR_W'(pc + ADDR_W'(1));
      default: next_loc = '0;
    endcase
  end

  assign bit_val       = mem_byte[opcode[3:1]];
  assign seq_pc        = ADDR_W'(pc + ADDR_W'(next_length));
  // Offset is signed, taken from the final operand byte
  assign rel_target    = ADDR_W'(seq_pc + {{(ADDR_W-8){
                         (next_mode == cid_mode_bit_test) ? operand2[7] : operand1[7]}},
                         (next_mode == cid_mode_bit_test) ? operand2 : operand1});
  // Read-sensitive registers and ROM cannot take a bit force
  assign protected_loc = (operand1 == `CID_ADDR_PORTD) | (operand1 == `CID_ADDR_SPI_STAT) |
                         (operand1 == `CID_ADDR_SCI_STAT) | (operand1 == `CID_ADDR_TMR_STAT) |
                         (operand1 == `CID_ADDR_CAP_HI) | (operand1 == `CID_ADDR_CAP_LO) |
                         (operand1 >= `CID_ROM_PAGE_BASE);

  // Cycle sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      remain <= 4'd0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        remain <= next_cycles - 4'd1;
        busy   <= (next_cycles != 4'd1);
        done   <= (next_cycles == 4'd1);
      end
      else if (busy)
      begin
        remain <= remain - 4'd1;
        if (remain == 4'd1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // Decoded results captured at instruction start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cycles           <= 4'd0;
      length           <= 2'd0;
      mode             <= cid_mode_inherent;
      op_class         <= cid_cls_none;
      func             <= cid_fn_none;
      bit_num          <= 3'd0;
      operand_location <= '0;
      illegal          <= 1'b0;
    end
    else if (start)
    begin
      cycles           <= next_cycles;
      length           <= next_length;
      mode             <= next_mode;
      op_class         <= next_class;
      func             <= next_func;
      bit_num          <= opcode[3:1];
      operand_location <= next_loc;
      illegal          <= (next_mode == cid_mode_illegal);
    end
  end

  // Flow and flag effects
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      next_pc <= '0;
      {jump_taken, carry_load, carry_value, bit_refused} <= 4'h0;
    end
    else if (start)
    begin
      next_pc <= seq_pc;
      {jump_taken, carry_load, carry_value, bit_refused} <= 4'h0;
      if ((next_class == cid_cls_rel_jump && cond_taken) || next_class == cid_cls_rel_call)
      begin
        next_pc    <= rel_target;
        jump_taken <= 1'b1;
      end
      else if (next_mode == cid_mode_bit_test)
      begin
        carry_load  <= 1'b1;
        carry_value <= bit_val;
        if (bit_val ^ opcode[0])
        begin
          next_pc    <= rel_target;
          jump_taken <= 1'b1;
        end
      end
      else if (next_mode == cid_mode_bit_setclr)
        bit_refused <= protected_loc;
    end
  end

  sequence s_start_rel;
    op_valid && !busy && opcode[7:4] == 4'h2;
  endsequence
  sequence s_product_run;
    busy [*8] ##1 busy [*2] ##1 !busy && done;
  endsequence

  a_rel_cycles: assert property (@(posedge clk) disable iff (rst)
    s_start_rel |=> cycles == 4'd3 && length == 2'd2)
    else $error("relative jump cycle count wrong");
  a_call_cycles: assert property (@(posedge clk) disable iff (rst)
    (op_valid && !busy && opcode == 8'hAD) |=> cycles == 4'd6 && jump_taken)
    else $error("rel_call timing wrong");
  a_never_jump: assert property (@(posedge clk) disable iff (rst)
    (op_valid && !busy && opcode == 8'h21) |=> !jump_taken)
    else $error("never-jump was taken");
  a_product_len: assert property (@(posedge clk) disable iff (rst)
    (op_valid && !busy && opcode == 8'h42) |=> s_product_run)
    else $error("product_op cycle count wrong");
  a_test_cycles: assert property (@(posedge clk) disable iff (rst)
    (op_valid && !busy && opcode == 8'h3D) |=> cycles == 4'd4)
    else $error("test_op direct cycles wrong");
  a_bit_carry: assert property (@(posedge clk) disable iff (rst)
    start && opcode[7:4] == 4'h0 |=> carry_load && carry_value == $past(mem_byte[opcode[3:1]]))
    else $error("tested bit not copied to carry");
  a_bit_page: assert property (@(posedge clk) disable iff (rst)
    start && opcode[7:5] == 3'b000 |=> operand_location[ADDR_W-1:8] == '0 && length != 2'd1)
    else $error("bit operation outside page zero");
  a_bit_refuse: assert property (@(posedge clk) disable iff (rst)
    (op_valid && !busy && opcode[7:4] == 4'h1 && operand1 == 8'h13) |=> bit_refused)
    else $error("protected location not refused");
  a_ctrl_cycles: assert property (@(posedge clk) disable iff (rst)
    (op_valid && !busy && opcode == 8'h9D) |=> cycles == 4'd2 && busy ##1 done)
    else $error("idle_op timing wrong");
endmodule : cid_decode

// ==== tb/cid_prog_mem.sv ====
// Program memory model feeding instruction and operand bytes
`timescale 1ns/1ps
module cid_prog_mem
(
  input  wire logic        clk,
  input  wire logic        act,
  input  wire logic [15:0] pc,
  output logic [7:0]       opcode,
  output logic [7:0]       operand1,
  output logic [7:0]       operand2,
  output logic [7:0]       mem_byte
);
  logic [7:0]  mem [0:65535];
  logic [31:0] now;
  logic [31:0] last;
  assign now = {mem[pc], mem[pc + 16'h0001], mem[pc + 16'h0002],
                mem[{8'h00, mem[pc + 16'h0001]}]};
  // Released bytes show inverted stale data so no leftover value can match
  assign {opcode, operand1, operand2, mem_byte} = act ? now : ~last;
  always_ff @(posedge clk) last <= now;
endmodule : cid_prog_mem

// ==== tb/tb_cpu8_instruction_decode.sv ====
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb_cpu8_instruction_decode
  import cid_pkg::*;
;
  logic clk, rst, op_valid, flag_carry, flag_zero, flag_half, flag_neg, flag_mask, irq_line;
  logic [7:0]  opcode, operand1, operand2, index_reg, mem_byte, o1, o2, mb;
  logic [15:0] pc, operand_location, next_pc, tgt;
  logic busy, done, illegal, jump_taken, carry_load, carry_value, bit_refused, bv;
  logic [3:0]  cycles, c;
  logic [1:0]  length;
  logic [2:0]  bit_num;
  cid_mode_type  mode;
  cid_class_type op_class;
  cid_func_type  func;
  int mismatches, checks_done, ticks;
  logic [3:0] lo_l [11] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hF};
  cid_func_type fn_l [11] = '{cid_fn_sign_flip_op, cid_fn_invert_op,
    cid_fn_shift_right_logical, cid_fn_rotate_right_carry, cid_fn_shift_right_signed,
    cid_fn_shift_left_logical, cid_fn_rotate_left_carry, cid_fn_subtract_one_op,
    cid_fn_add_one_op, cid_fn_test_op, cid_fn_zero_op};
  logic [3:0] hi_l [5] = '{4'h4, 4'h5, 4'h3, 4'h7, 4'h6};
  logic [7:0] ct_op [13] = '{8'h99, 8'h98, 8'h9B, 8'h9A, 8'h97, 8'h9F, 8'h9C, 8'h9D,
    8'h83, 8'h81, 8'h80, 8'h8E, 8'h8F};
  logic [3:0] ct_cy [13] = '{4'd2, 4'd2, 4'd2, 4'd2, 4'd2, 4'd2, 4'd2, 4'd2,
    4'd10, 4'd6, 4'd9, 4'd2, 4'd2};
  cid_class_type ct_cl [13] = '{cid_cls_carry_force_high, cid_cls_carry_force_low,
    cid_cls_mask_force_high, cid_cls_mask_force_low, cid_cls_acc_to_index,
    cid_cls_index_to_acc, cid_cls_stack_ptr_init, cid_cls_idle_op, cid_cls_soft_trap,
    cid_cls_call_return, cid_cls_trap_return, cid_cls_stop, cid_cls_wait};
  logic [7:0] prot [9] = '{8'h03, 8'h0B, 8'h10, 8'h13, 8'h14, 8'h15, 8'hD0, 8'hFF, 8'hCF};

  cid_decode DUT (.clk(clk), .rst(rst), .op_valid(op_valid), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .index_reg(index_reg), .pc(pc),
    .mem_byte(mem_byte), .flag_carry(flag_carry), .flag_zero(flag_zero),
    .flag_half(flag_half), .flag_neg(flag_neg), .flag_mask(flag_mask),
    .irq_line(irq_line), .busy(busy), .done(done), .illegal(illegal), .cycles(cycles),
    .length(length), .mode(mode), .op_class(op_class), .func(func), .bit_num(bit_num),
    .operand_location(operand_location), .next_pc(next_pc), .jump_taken(jump_taken),
    .carry_load(carry_load), .carry_value(carry_value), .bit_refused(bit_refused));
  cid_prog_mem PMEM (.clk(clk), .act(op_valid | busy), .pc(pc), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .mem_byte(mem_byte));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end

  function automatic logic cond(input logic [7:0] op);
    logic r;
    case (op[3:1])
      3'd0: r = 1'b1;
      3'd1: r = ~(flag_carry | flag_zero);
      3'd2: r = ~flag_carry;
      3'd3: r = ~flag_zero;
      3'd4: r = ~flag_half;
      3'd5: r = ~flag_neg;
      3'd6: r = ~flag_mask;
      default: r = ~irq_line;
    endcase
    return r ^ op[0];
  endfunction : cond

  // Bytes on which a bit force must be refused
  function automatic logic guarded(input logic [7:0] a);
    return a >= 8'hD0 || a inside {8'h03, 8'h0B, 8'h10, 8'h13, 8'h14, 8'h15};
  endfunction : guarded

  // Places bytes in memory, takes the request, counts edges up to done
  task automatic issue(input logic [7:0] op, input logic [3:0] ecyc, input bit poke);
    int n;
    @(posedge clk);
    #1;
    pc = 16'h0400 + 16'($urandom_range(0, 16'hF000));
    PMEM.mem[pc] = op;
    PMEM.mem[pc + 16'h0001] = o1;
    PMEM.mem[pc + 16'h0002] = o2;
    PMEM.mem[{8'h00, o1}] = 8'($urandom);
    {flag_carry, flag_zero, flag_half, flag_neg, flag_mask, irq_line} = 6'($urandom);
    index_reg = 8'($urandom);
    op_valid = 1'b1;
    // Taken edge counts as the first cycle
    n = 1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      // A request while busy must be ignored
      op_valid = poke && n == 3 && done !== 1'b1;
    end while (done !== 1'b1 && n < 20);
    chk(n, ecyc);
    chk(cycles, ecyc);
    chk(busy, 1'b0);
  endtask : issue

  initial
  begin
    {op_valid, o1, o2, pc, index_reg} = '0;
    rst = 1'b1;
    {flag_carry, flag_zero, flag_half, flag_neg, flag_mask, irq_line} = '0;
    mismatches = 0;
    checks_done = 0;
    ticks = 0;
    void'($urandom(32'hBF72AFF5));
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({busy, done, op_class}, {2'b00, cid_cls_none});
    for (int i = 0; i < 5; i++)
      for (int j = 0; j < 11; j++)
      begin
        {o1, o2} = 16'($urandom);
        c = (i < 2) ? 4'd3 : (i == 4 ? 4'd6 : 4'd5);
        if (i > 1 && j == 9) c = c - 4'd1;
        issue({hi_l[i], lo_l[j]}, c, 0);
        chk(length, (i == 2 || i == 4) ? 2'd2 : 2'd1);
        chk({op_class, func}, {cid_cls_rmw, fn_l[j]});
        if (i == 2) chk(operand_location, {8'h00, o1});
        if (i == 3) chk(operand_location, {8'h00, index_reg});
        if (i == 4) chk(operand_location, 16'(index_reg) + 16'(o1));
        chk(next_pc, pc + ((i == 2 || i == 4) ? 16'h0002 : 16'h0001));
      end
    issue(8'h42, 4'd11, 1);
    chk({length, op_class, mode}, {2'd1, cid_cls_product, cid_mode_inherent});
    for (int k = 0; k < 64; k++)
    begin
      o1 = (k < 16) ? 8'h80 : (k < 32 ? 8'h7F : 8'($urandom));
      issue(8'h20 + 8'(k % 16), 4'd3, 0);
      bv = cond(8'h20 + 8'(k % 16));
      tgt = pc + 16'h0002 + (bv ? {{8{o1[7]}}, o1} : 16'h0000);
      chk({jump_taken, length}, {bv, 2'd2});
      chk(next_pc, tgt);
    end
    issue(8'hAD, 4'd6, 0);
    chk({length, op_class}, {2'd2, cid_cls_rel_call});
    chk({jump_taken, next_pc}, {1'b1, pc + 16'h0002 + {{8{o1[7]}}, o1}});
    for (int k = 0; k < 96; k++)
    begin
      o1 = (k < 32) ? prot[k % 9] : 8'($urandom);
      o2 = 8'($urandom);
      issue(8'(k % 32), 4'd5, 0);
      mb = PMEM.mem[{8'h00, o1}];
      bv = mb[(k % 16) / 2];
      chk({operand_location, bit_num}, {8'h00, o1, 3'((k % 16) / 2)});
      if (k % 32 < 16)
      begin
        tgt = pc + 16'h0003 + ((bv ^ k[0]) ? {{8{o2[7]}}, o2} : 16'h0000);
        chk({length, jump_taken, next_pc}, {2'd3, bv ^ k[0], tgt});
        chk({carry_load, carry_value}, {1'b1, bv});
      end
      else
      begin
        chk({length, next_pc}, {2'd2, pc + 16'h0002});
        chk(op_class, k[0] ? cid_cls_bit_force_low : cid_cls_bit_force_high);
        chk(bit_refused, guarded(o1));
      end
    end
    for (int k = 0; k < 13; k++)
    begin
      issue(ct_op[k], ct_cy[k], 0);
      chk({illegal, op_class, length}, {1'b0, ct_cl[k], 2'd1});
      chk(next_pc, pc + 16'h0001);
    end
    // Hole in an RMW column decodes as illegal
    issue(8'h41, 4'd2, 0);
    chk({illegal, op_class, func}, {1'b1, cid_cls_none, cid_fn_none});
    end_sim();
  end
endmodule : tb_cpu8_instruction_decode
